// file: src/obpc_map.svh
// register addresses, field positions, reset values and status byte layout of the otg control bank
`ifndef OBPC_MAP_SVH
`define OBPC_MAP_SVH

// register addresses on the link register port
`define OBPC_ADDR_WRITE 6'h0A
`define OBPC_ADDR_SET 6'h0B
`define OBPC_ADDR_CLEAR 6'h0C

// field positions inside the control register
`define OBPC_BIT_OVERCURRENT_SOURCE_SELECT 7
`define OBPC_BIT_EXTERNAL_SUPPLY_SELECT 6
`define OBPC_BIT_SUPPLY_DRIVE_ON 5
`define OBPC_BIT_SUPPLY_PULSE_CHARGE 4
`define OBPC_BIT_SUPPLY_DISCHARGE 3
`define OBPC_BIT_MINUS_LINE_PULLDOWN 2
`define OBPC_BIT_PLUS_LINE_PULLDOWN 1
`define OBPC_BIT_CABLE_IDENT_SAMPLER 0

// reset value: both data-line pull-downs on, everything else off
`define OBPC_CTRL_RESET 8'h06

// read answer for an address outside the bank
`define OBPC_UNMAPPED_READ 8'h00

// receive-command status byte layout
`define OBPC_RXCMD_BIT_SESSION_END 3
`define OBPC_RXCMD_BIT_ID_LEVEL 6

`endif

// file: src/obpc_pkg.sv
// types shared by the otg control bank
package obpc_pkg;

   // control register, msb first
   typedef struct packed {
      logic overcurrent_source_select;
      logic external_supply_select;
      logic supply_drive_on;
      logic supply_pulse_charge;
      logic supply_discharge;
      logic minus_line_pulldown;
      logic plus_line_pulldown;
      logic cable_ident_sampler;
   } obpc_ctrl_s;

   // one register access from the link
   typedef struct packed {
      logic valid;
      logic write;
      logic [5:0] addr;
      logic [7:0] data;
   } obpc_reg_cmd_s;

   // answer to a register access
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } obpc_reg_rsp_s;

   // receive-command byte towards the link
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } obpc_rxcmd_s;

   // state of the link-to-core word handshake
   typedef enum logic {
      OBPC_XFER_IDLE = 1'b0,
      OBPC_XFER_WAIT = 1'b1
   } obpc_xfer_e;

endpackage

// file: src/obpc_sync2.sv
// two flip-flop synchroniser for a group of levels
module obpc_sync2 #(
   parameter int WIDTH = 1
) (
   // destination clock and reset
   input wire logic clk,
   input wire logic rst,
   // level in, level out
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] hold_reg;

   // the first stage is read by the second stage only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         hold_reg <= '0;
      end else begin
         meta_reg <= d;
         hold_reg <= meta_reg;
      end
   end

   assign q = hold_reg;

endmodule

// file: src/obpc_otg_power_and_pull_control.sv
// otg power and pull control register bank with its link and core clock domains
//
// Overview of operation
// R1 - control register at 0Ah, set 0Bh, clear 0Ch
// R2 - write replaces, set ORs, clear clears ones
// R3 - overcurrent select picks internal or external indicator
// R4 - internal supply: charge pump, switch output released
// R5 - external supply: power switch output driven low
// R6 - drive bit commands five volts on bus; here it gates the pump only, the switch follows external select alone
// R7 - charge bit charges bus supply through resistor
// R8 - link checks discharged bus and 2 ms SE0; the link model checks the discharged bus only, not SE0
// R9 - discharge bit discharges bus through resistor
// R10 - link clears discharge after session end rises
// R11 - minus-line pull-down follows its bit, resets on
// R12 - plus-line pull-down follows its bit, resets on
// R13 - ident bit enables pull-up and line sampling
// R14 - session end flag follows comparator, sent in rxcmd
`include "obpc_map.svh"

module obpc_otg_power_and_pull_control
   import obpc_pkg::*;
(
   // core clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // link clock and register port
   input wire logic link_clk,
   input wire obpc_reg_cmd_s reg_cmd,
   output obpc_reg_rsp_s reg_rsp,
   output obpc_rxcmd_s rxcmd,
   // analog and pin inputs
   input wire logic int_vbus_valid_in,
   input wire logic fault_in,
   input wire logic session_end_cmp_in,
   input wire logic ident_line_in,
   // supply control
   output logic supply_valid,
   output logic charge_pump_enable,
   output logic power_switch_out_n,
   output logic power_switch_oe,
   output logic pulse_charge_enable,
   output logic discharge_enable,
   // line control and status
   output logic minus_line_pulldown,
   output logic plus_line_pulldown,
   output logic cable_ident_pullup,
   output logic ident_level,
   output logic session_end_flag
);

   //----------------------------------------------------------------
   // link domain reset
   //----------------------------------------------------------------
   // asserted at once with sys_rst, released on a link clock edge
   logic link_rst_n_sync;
   logic link_rst;

   obpc_sync2 #(.WIDTH(1)) u_link_rst (
      .clk(link_clk),
      .rst(sys_rst),
      .d(1'b1),
      .q(link_rst_n_sync)
   );

   assign link_rst = ~link_rst_n_sync;

   //----------------------------------------------------------------
   // link domain: register access
   //----------------------------------------------------------------
   obpc_ctrl_s ctrl_reg;
   obpc_ctrl_s ctrl_next;
   obpc_reg_rsp_s rsp_reg;
   obpc_reg_rsp_s rsp_next;
   logic in_bank;

   always_comb begin
      ctrl_next = ctrl_reg;
      rsp_next = '0;
      in_bank = (reg_cmd.addr == `OBPC_ADDR_WRITE) ||
                (reg_cmd.addr == `OBPC_ADDR_SET) ||
                (reg_cmd.addr == `OBPC_ADDR_CLEAR); // R1
      if (reg_cmd.valid) begin
         rsp_next.valid = 1'b1;
         if (reg_cmd.write) begin
            rsp_next.data = `OBPC_UNMAPPED_READ;
            unique case (reg_cmd.addr)
               `OBPC_ADDR_WRITE: ctrl_next = obpc_ctrl_s'(reg_cmd.data); // R2
               `OBPC_ADDR_SET: ctrl_next = obpc_ctrl_s'(ctrl_reg | reg_cmd.data); // R2
               `OBPC_ADDR_CLEAR: ctrl_next = obpc_ctrl_s'(ctrl_reg & ~reg_cmd.data); // R2
               default: ctrl_next = ctrl_reg;
            endcase
         end else begin
            // all three addresses read back the same contents
            rsp_next.data = in_bank ? ctrl_reg : `OBPC_UNMAPPED_READ; // R1
         end
      end
   end

   always_ff @(posedge link_clk or posedge link_rst) begin
      if (link_rst) begin
         ctrl_reg <= obpc_ctrl_s'(`OBPC_CTRL_RESET); // R11 R12
         rsp_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
         rsp_reg <= rsp_next;
      end
   end

   assign reg_rsp = rsp_reg;

   //----------------------------------------------------------------
   // link domain: hand the register word to the core domain
   //----------------------------------------------------------------
   // the link never waits for the crossing: a newer value written
   // while a transfer is open is sent two link cycles after the ack returns
   obpc_xfer_e xfer_reg;
   obpc_xfer_e xfer_next;
   obpc_ctrl_s sent_reg;
   obpc_ctrl_s sent_next;
   logic req_tog_reg;
   logic req_tog_next;
   logic ack_tog_sync;

   always_comb begin
      xfer_next = xfer_reg;
      sent_next = sent_reg;
      req_tog_next = req_tog_reg;
      unique case (xfer_reg)
         OBPC_XFER_IDLE: begin
            if (ctrl_reg != sent_reg) begin
               sent_next = ctrl_reg;
               req_tog_next = ~req_tog_reg;
               xfer_next = OBPC_XFER_WAIT;
            end
         end
         OBPC_XFER_WAIT: begin
            if (ack_tog_sync == req_tog_reg) begin
               xfer_next = OBPC_XFER_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge link_clk or posedge link_rst) begin
      if (link_rst) begin
         xfer_reg <= OBPC_XFER_IDLE;
         sent_reg <= obpc_ctrl_s'(`OBPC_CTRL_RESET);
         req_tog_reg <= 1'b0;
      end else begin
         xfer_reg <= xfer_next;
         sent_reg <= sent_next;
         req_tog_reg <= req_tog_next;
      end
   end

   //----------------------------------------------------------------
   // core domain: take the register word
   //----------------------------------------------------------------
   logic req_tog_sync;
   logic ack_tog_reg;
   logic ack_tog_next;
   obpc_ctrl_s core_ctrl_reg;
   obpc_ctrl_s core_ctrl_next;

   obpc_sync2 #(.WIDTH(1)) u_req_sync (
      .clk(clock),
      .rst(sys_rst),
      .d(req_tog_reg),
      .q(req_tog_sync)
   );

   obpc_sync2 #(.WIDTH(1)) u_ack_sync (
      .clk(link_clk),
      .rst(link_rst),
      .d(ack_tog_reg),
      .q(ack_tog_sync)
   );

   // sent_reg is held still until the ack toggle comes back
   always_comb begin
      ack_tog_next = ack_tog_reg;
      core_ctrl_next = core_ctrl_reg;
      if (req_tog_sync != ack_tog_reg) begin
         core_ctrl_next = sent_reg;
         ack_tog_next = req_tog_sync;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ack_tog_reg <= 1'b0;
         core_ctrl_reg <= obpc_ctrl_s'(`OBPC_CTRL_RESET);
      end else begin
         ack_tog_reg <= ack_tog_next;
         core_ctrl_reg <= core_ctrl_next;
      end
   end

   //----------------------------------------------------------------
   // core domain: pin inputs
   //----------------------------------------------------------------
   logic [3:0] pins_sync;
   logic int_vbus_s;
   logic fault_s;
   logic session_end_flag_s;
   logic ident_s;

   obpc_sync2 #(.WIDTH(4)) u_pin_sync (
      .clk(clock),
      .rst(sys_rst),
      .d({int_vbus_valid_in, fault_in, session_end_cmp_in, ident_line_in}),
      .q(pins_sync)
   );

   assign {int_vbus_s, fault_s, session_end_flag_s, ident_s} = pins_sync;

   //----------------------------------------------------------------
   // core domain: supply and line outputs
   //----------------------------------------------------------------
   logic supply_valid_reg;
   logic supply_valid_next;
   logic pump_reg;
   logic pump_next;
   logic power_switch_out_n_reg;
   logic power_switch_out_n_next;
   logic psw_oe_reg;
   logic psw_oe_next;
   logic charge_reg;
   logic charge_next;
   logic discharge_reg;
   logic discharge_next;
   logic dm_pd_reg;
   logic dm_pd_next;
   logic dp_pd_reg;
   logic dp_pd_next;
   logic id_pu_reg;
   logic id_pu_next;
   logic id_level_reg;
   logic id_level_next;
   logic session_end_flag_reg;
   logic session_end_flag_next;

   always_comb begin
      supply_valid_next = core_ctrl_reg.overcurrent_source_select ?
                          fault_s : int_vbus_s; // R3
      // the switch pin is open drain: only ever pulled low
      power_switch_out_n_next = ~core_ctrl_reg.external_supply_select; // R4 R5
      psw_oe_next = core_ctrl_reg.external_supply_select; // R4 R5
      // with an external source the internal pump stays off even if
      // the drive bit is set, so the two never fight on the bus
      pump_next = core_ctrl_reg.supply_drive_on &
                  ~core_ctrl_reg.external_supply_select; // R4 R6
      // charge safety is the link's duty, so no interlock here
      charge_next = core_ctrl_reg.supply_pulse_charge; // R7 R8
      // discharge runs until the link clears it again
      discharge_next = core_ctrl_reg.supply_discharge; // R9 R10
      dm_pd_next = core_ctrl_reg.minus_line_pulldown; // R11
      dp_pd_next = core_ctrl_reg.plus_line_pulldown; // R12
      id_pu_next = core_ctrl_reg.cable_ident_sampler; // R13
      // sampler off reads low and saves the pull-up current
      id_level_next = core_ctrl_reg.cable_ident_sampler & ident_s; // R13
      session_end_flag_next = session_end_flag_s; // R14
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         supply_valid_reg <= 1'b0;
         pump_reg <= 1'b0;
         power_switch_out_n_reg <= 1'b1;
         psw_oe_reg <= 1'b0;
         charge_reg <= 1'b0;
         discharge_reg <= 1'b0;
         dm_pd_reg <= 1'b1;
         dp_pd_reg <= 1'b1;
         id_pu_reg <= 1'b0;
         id_level_reg <= 1'b0;
         session_end_flag_reg <= 1'b0;
      end else begin
         supply_valid_reg <= supply_valid_next;
         pump_reg <= pump_next;
         power_switch_out_n_reg <= power_switch_out_n_next;
         psw_oe_reg <= psw_oe_next;
         charge_reg <= charge_next;
         discharge_reg <= discharge_next;
         dm_pd_reg <= dm_pd_next;
         dp_pd_reg <= dp_pd_next;
         id_pu_reg <= id_pu_next;
         id_level_reg <= id_level_next;
         session_end_flag_reg <= session_end_flag_next;
      end
   end

   assign supply_valid = supply_valid_reg;
   assign charge_pump_enable = pump_reg;
   assign power_switch_out_n = power_switch_out_n_reg;
   assign power_switch_oe = psw_oe_reg;
   assign pulse_charge_enable = charge_reg;
   assign discharge_enable = discharge_reg;
   assign minus_line_pulldown = dm_pd_reg;
   assign plus_line_pulldown = dp_pd_reg;
   assign cable_ident_pullup = id_pu_reg;
   assign ident_level = id_level_reg;
   assign session_end_flag = session_end_flag_reg;

   //----------------------------------------------------------------
   // link domain: receive-command on status change
   //----------------------------------------------------------------
   logic [1:0] stat_sync;
   logic [1:0] stat_last_reg;
   logic [1:0] stat_last_next;
   obpc_rxcmd_s rxcmd_reg;
   obpc_rxcmd_s rxcmd_next;

   obpc_sync2 #(.WIDTH(2)) u_stat_sync (
      .clk(link_clk),
      .rst(link_rst),
      .d({session_end_flag_reg, id_level_reg}),
      .q(stat_sync)
   );

   always_comb begin
      stat_last_next = stat_sync;
      rxcmd_next = '0;
      if (stat_sync != stat_last_reg) begin
         rxcmd_next.valid = 1'b1; // R14
         rxcmd_next.data[`OBPC_RXCMD_BIT_SESSION_END] = stat_sync[1]; // R14
         rxcmd_next.data[`OBPC_RXCMD_BIT_ID_LEVEL] = stat_sync[0];
      end
   end

   always_ff @(posedge link_clk or posedge link_rst) begin
      if (link_rst) begin
         stat_last_reg <= 2'h0;
         rxcmd_reg <= '0;
      end else begin
         stat_last_reg <= stat_last_next;
         rxcmd_reg <= rxcmd_next;
      end
   end

   assign rxcmd = rxcmd_reg;

endmodule

// file: sim/obpc_otg_power_and_pull_control_properties.sv
// concurrent checks on the ports of the otg control bank
module obpc_otg_power_and_pull_control_properties
   import obpc_pkg::*;
(
   // clocks and reset
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic link_clk,
   // link side
   input wire obpc_reg_cmd_s reg_cmd,
   input wire obpc_reg_rsp_s reg_rsp,
   input wire obpc_rxcmd_s rxcmd,
   // pins
   input wire logic int_vbus_valid_in,
   input wire logic fault_in,
   input wire logic session_end_cmp_in,
   input wire logic supply_valid,
   input wire logic charge_pump_enable,
   input wire logic power_switch_out_n,
   input wire logic power_switch_oe,
   input wire logic cable_ident_pullup,
   input wire logic ident_level,
   input wire logic session_end_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------
   // link domain
   // ----------------
   property p_rsp_each;
      @(posedge link_clk) disable iff (sys_rst) reg_cmd.valid |=> reg_rsp.valid;
   endproperty
   a_rsp_each: assert property (p_rsp_each) else $error("access left unanswered");
   property p_rsp_lone;
      @(posedge link_clk) disable iff (sys_rst) !reg_cmd.valid |=> !reg_rsp.valid;
   endproperty
   a_rsp_lone: assert property (p_rsp_lone) else $error("answer without access");
   property p_wr_zero;
      @(posedge link_clk) disable iff (sys_rst)
      reg_cmd.valid && reg_cmd.write |=> reg_rsp.data == 8'h00;
   endproperty
   a_wr_zero: assert property (p_wr_zero) else $error("write answer carries data");
   property p_rx_layout;
      @(posedge link_clk) disable iff (sys_rst) rxcmd.valid |-> (rxcmd.data & 8'hB7) == 8'h00;
   endproperty
   a_rx_layout: assert property (p_rx_layout) else $error("status byte has stray bits");
   // ----------------
   // core domain
   // ----------------
   property p_switch;
      @(posedge clock) disable iff (sys_rst) power_switch_oe != power_switch_out_n;
   endproperty
   a_switch: assert property (p_switch) else $error("switch pin not driven low");
   property p_pump;
      @(posedge clock) disable iff (sys_rst) charge_pump_enable |-> !power_switch_oe;
   endproperty
   a_pump: assert property (p_pump) else $error("pump on with external supply");
   property p_src;
      @(posedge clock) disable iff (sys_rst)
      (fault_in && int_vbus_valid_in)[*5] |-> supply_valid;
   endproperty
   a_src: assert property (p_src) else $error("supply valid lost");
   property p_sess;
      @(posedge clock) disable iff (sys_rst) session_end_cmp_in[*5] |-> session_end_flag;
   endproperty
   a_sess: assert property (p_sess) else $error("session end not shown");
   property p_ident;
      @(posedge clock) disable iff (sys_rst) (!cable_ident_pullup)[*2] |-> !ident_level;
   endproperty
   a_ident: assert property (p_ident) else $error("ident sampled while off");
endmodule

bind obpc_otg_power_and_pull_control obpc_otg_power_and_pull_control_properties u_props (.clock, .sys_rst, .link_clk, .reg_cmd,
   .reg_rsp, .rxcmd, .int_vbus_valid_in, .fault_in, .session_end_cmp_in, .supply_valid,
   .charge_pump_enable, .power_switch_out_n, .power_switch_oe, .cable_ident_pullup,
   .ident_level, .session_end_flag);

// file: sim/obpc_link_model.sv
// link controller model on the register port of the otg control bank
`include "obpc_map.svh"
module obpc_link_model
   import obpc_pkg::*;
(
   // link clock and reset
   input wire logic link_clk,
   input wire logic sys_rst,
   // register port and status bytes
   output obpc_reg_cmd_s reg_cmd,
   input wire obpc_reg_rsp_s reg_rsp,
   input wire obpc_rxcmd_s rxcmd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic session_end_flag_seen;
   logic [7:0] last_rx;
   initial reg_cmd = '0;
   // after a quiet spell the last status byte mirrors the present status
   always @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         session_end_flag_seen <= 1'b0;
         last_rx <= 8'h00;
      end else if (rxcmd.valid) begin
         session_end_flag_seen <= rxcmd.data[`OBPC_RXCMD_BIT_SESSION_END];
         last_rx <= rxcmd.data;
      end
   end
   // idle fields carry inverted junk so a stale value is never taken for a fresh one
   task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d,
         output obpc_reg_rsp_s r);
      @(posedge link_clk);
      reg_cmd <= {1'b1, wr, a, d};
      @(posedge link_clk);
      reg_cmd <= {1'b0, ~wr, ~a, ~d};
      @(posedge link_clk);
      r = reg_rsp;
   endtask
   task automatic discharge_session(output obpc_reg_rsp_s r, output logic seen);
      access(1'b1, `OBPC_ADDR_SET, 8'h08, r);
      seen = 1'b0;
      for (int i = 0; i < 400 && !seen; i++) begin
         @(posedge link_clk);
         seen = rxcmd.valid && rxcmd.data[`OBPC_RXCMD_BIT_SESSION_END];
      end
      access(1'b1, `OBPC_ADDR_CLEAR, 8'h08, r);
   endtask
   // data-line idle time is not modelled, only the discharged bus
   task automatic pulse_charge(output obpc_reg_rsp_s r, output logic sent);
      sent = session_end_flag_seen;
      if (sent) access(1'b1, `OBPC_ADDR_SET, 8'h10, r);
   endtask
endmodule

// file: sim/obpc_otg_power_and_pull_control_tb.sv
// self-checking bench for the otg control bank
`include "obpc_map.svh"
module obpc_otg_power_and_pull_control_tb
   import obpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic link_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic int_vbus_valid_in = 1'b0;
   logic fault_in = 1'b0;
   logic session_end_cmp_in = 1'b0;
   logic ident_line_in = 1'b0;
   obpc_reg_cmd_s reg_cmd;
   obpc_reg_rsp_s reg_rsp, rsp;
   obpc_rxcmd_s rxcmd;
   logic supply_valid, charge_pump_enable, power_switch_out_n, power_switch_oe;
   logic pulse_charge_enable, discharge_enable, minus_line_pulldown, plus_line_pulldown;
   logic cable_ident_pullup, ident_level, session_end_flag, seen;
   logic [7:0] d;
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;
   int ctrl_m = 8'h06;
   always #2.5 clock = ~clock;
   initial #1.1 forever #3 link_clk = ~link_clk;
   obpc_otg_power_and_pull_control DUT (.clock, .sys_rst, .link_clk, .reg_cmd, .reg_rsp, .rxcmd,
      .int_vbus_valid_in, .fault_in, .session_end_cmp_in, .ident_line_in, .supply_valid,
      .charge_pump_enable, .power_switch_out_n, .power_switch_oe, .pulse_charge_enable,
      .discharge_enable, .minus_line_pulldown, .plus_line_pulldown, .cable_ident_pullup,
      .ident_level, .session_end_flag);
   obpc_link_model link (.link_clk, .sys_rst, .reg_cmd, .reg_rsp, .rxcmd);
   // ----------------
   // checking
   // ----------------
   task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_pin(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic read_all;
      for (int a = `OBPC_ADDR_WRITE; a <= `OBPC_ADDR_CLEAR; a++) begin
         link.access(1'b0, a[5:0], 8'($urandom), rsp);
         chk_pin("answer valid", 1'b1, rsp.valid);
         chk_reg("register", ctrl_m[7:0], rsp.data);
      end
   endtask
   // waits out the crossing before looking at the pins
   task automatic chk_pins;
      logic [7:0] c;
      logic [7:0] s;
      c = ctrl_m[7:0];
      repeat (15) @(posedge clock);
      chk_pin("supply valid", c[7] ? fault_in : int_vbus_valid_in, supply_valid);
      chk_pin("switch out", ~c[6], power_switch_out_n);
      chk_pin("switch enable", c[6], power_switch_oe);
      chk_pin("pump", c[5] & ~c[6], charge_pump_enable);
      chk_pin("charge", c[4], pulse_charge_enable);
      chk_pin("discharge", c[3], discharge_enable);
      chk_pin("minus pulldown", c[2], minus_line_pulldown);
      chk_pin("plus pulldown", c[1], plus_line_pulldown);
      chk_pin("ident pullup", c[0], cable_ident_pullup);
      chk_pin("ident level", c[0] & ident_line_in, ident_level);
      chk_pin("session end", session_end_cmp_in, session_end_flag);
      s = 8'h00;
      s[`OBPC_RXCMD_BIT_ID_LEVEL] = c[0] & ident_line_in;
      s[`OBPC_RXCMD_BIT_SESSION_END] = session_end_cmp_in;
      chk_reg("status byte", s, link.last_rx);
   endtask
   task automatic test_done;
      if (failures == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         test_done();
      end
   end
   // ----------------
   // scenarios
   // ----------------
   initial begin
      void'($urandom(32'hD510F7DE));
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (4) @(posedge link_clk);
      read_all();
      chk_pins();
      for (int i = 0; i < 24; i++) begin
         d = 8'($urandom);
         @(posedge clock);
         {fault_in, int_vbus_valid_in, ident_line_in, session_end_cmp_in} <= 4'($urandom);
         link.access(1'b1, 6'(`OBPC_ADDR_WRITE + i % 3), d, rsp);
         chk_reg("write answer", 8'h00, rsp.data);
         ctrl_m = i % 3 == 0 ? d : i % 3 == 1 ? ctrl_m | d : ctrl_m & ~d;
         read_all();
         chk_pins();
      end
      link.access(1'b1, 6'h0D, 8'hFF, rsp);
      link.access(1'b0, 6'h0D, 8'h00, rsp);
      chk_reg("unmapped read", `OBPC_UNMAPPED_READ, rsp.data);
      read_all();
      @(posedge clock);
      session_end_cmp_in <= 1'b0;
      repeat (20) @(posedge clock);
      fork
         link.discharge_session(rsp, seen);
         begin
            repeat (30) @(posedge clock);
            chk_pin("discharging", 1'b1, discharge_enable);
            session_end_cmp_in <= 1'b1;
         end
      join
      chk_pin("session end reported", 1'b1, seen);
      ctrl_m = ctrl_m & ~8'h08;
      read_all();
      chk_pins();
      link.pulse_charge(rsp, seen);
      chk_pin("charge request", 1'b1, seen);
      ctrl_m = ctrl_m | 8'h10;
      chk_pins();
      test_done();
   end
endmodule
